// ---- design/power_sequencer.sv ----
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module power_sequencer
  import power_sequencer_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [7:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // pins and comparators, asynchronous
  input wire logic TEST_RESET_N_IN,
  input wire logic SUPPLY_RAIL_OK_IN,
  input wire logic UNDERVOLTAGE_LOCKOUT_OK_IN,
  input wire logic BATTERY_BROWNOUT_SENSE_IN,
  input wire logic BACKUP_BATTERY_OK_IN,
  input wire logic CHARGER_VOLTAGE_OK_IN,
  input wire logic LOCAL_POWER_BUTTON_N_IN,
  input wire logic REMOTE_POWER_BUTTON_N_IN,
  input wire logic WAKEUP_REQUEST_IN,
  input wire logic SLOW_CLOCK_IN,
  input wire logic MASTER_CLOCK_OK_IN,
  // converter event, same clock
  input wire logic ADC_EOC_IN,
  // supplies and interrupts
  output logic RTC_SUPPLY_OUT,
  output logic SUPPLY_ACTIVE_OUT,
  output logic SUPPLY_SLEEP_OUT,
  output logic INTERNAL_RESET_N_OUT,
  output logic BANDGAP_SLOW_OUT,
  output logic EMERGENCY_IRQ_N_OUT,
  output logic EVENT_IRQ_N_OUT,
  output logic [3:0] STATE_OUT
);
  // =====================================================
  // synchronisers
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  assign async_in = {TEST_RESET_N_IN, SUPPLY_RAIL_OK_IN,
    UNDERVOLTAGE_LOCKOUT_OK_IN, BATTERY_BROWNOUT_SENSE_IN,
    BACKUP_BATTERY_OK_IN, CHARGER_VOLTAGE_OK_IN,
    LOCAL_POWER_BUTTON_N_IN, REMOTE_POWER_BUTTON_N_IN,
    WAKEUP_REQUEST_IN, SLOW_CLOCK_IN, MASTER_CLOCK_OK_IN};

  // reset value is idle level: buttons released, rails low
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_B_IN)
    begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end
    else
    begin
      sync1_ff <= async_in; // see RULE_23
      sync2_ff <= sync1_ff;
    end
  end

  logic test_rst_n, rail_ok, undervoltage_lockout_ok, brownout, backup_ok;
  logic charger_ok, local_n, remote_n, wakeup, slow_clk;
  logic master_ok;
  assign {test_rst_n, rail_ok, undervoltage_lockout_ok, brownout, backup_ok,
    charger_ok, local_n, remote_n, wakeup, slow_clk,
    master_ok} = sync2_ff;

  // whole device reset; test pin has no conditions
  logic sys_rst;
  assign sys_rst = !RST_B_IN || !test_rst_n; // see RULE_02
  logic seq_rst;
  assign seq_rst = sys_rst || !rail_ok; // see RULE_01

  // =====================================================
  // edge detection and slow tick
  logic slow_clk_d_ff, wakeup_d_ff, charger_d_ff, brownout_d_ff;
  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      slow_clk_d_ff <= 1'b0;
      wakeup_d_ff <= 1'b0;
      charger_d_ff <= 1'b0;
      // idle sync level, so no false brownout edge after reset
      brownout_d_ff <= 1'b1;
    end
    else
    begin
      slow_clk_d_ff <= slow_clk;
      wakeup_d_ff <= wakeup;
      charger_d_ff <= charger_ok;
      brownout_d_ff <= brownout;
    end
  end
  logic tick;
  // all sequence timing waits on this tick
  assign tick = slow_clk && !slow_clk_d_ff; // see RULE_12

  // switched on by test pin; survives the test reset itself
  logic test_started_ff;
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_B_IN || !rail_ok)
      test_started_ff <= 1'b0;
    else if (!test_rst_n)
      test_started_ff <= 1'b1;
  end

  // =====================================================
  // shared debouncer, one button at a time
  logic deb_local_ff, deb_remote_ff, serve_remote_ff, busy_ff;
  logic [10:0] deb_cnt_ff;
  logic local_diff, remote_diff;
  assign local_diff = local_n != deb_local_ff;
  assign remote_diff = remote_n != deb_remote_ff;
  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      deb_local_ff <= 1'b1;
      deb_remote_ff <= 1'b1;
      serve_remote_ff <= 1'b0;
      busy_ff <= 1'b0;
      deb_cnt_ff <= 11'h000;
    end
    else if (!busy_ff)
    begin
      // the other button simply waits its turn
      if (local_diff || remote_diff) // see RULE_09
      begin
        busy_ff <= 1'b1;
        serve_remote_ff <= !local_diff;
        deb_cnt_ff <= 11'h000;
      end
    end
    else if (tick)
    begin
      if (deb_cnt_ff == DEBOUNCE_COUNT - 11'd1) // see RULE_22
      begin
        busy_ff <= 1'b0;
        if (serve_remote_ff)
          deb_remote_ff <= remote_n;
        else
          deb_local_ff <= local_n;
      end
      else
        deb_cnt_ff <= deb_cnt_ff + 11'd1;
    end
  end

  logic deb_local_d_ff, deb_remote_d_ff;
  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      deb_local_d_ff <= 1'b1;
      deb_remote_d_ff <= 1'b1;
    end
    else
    begin
      deb_local_d_ff <= deb_local_ff;
      deb_remote_d_ff <= deb_remote_ff;
    end
  end
  logic local_fall, remote_fall, remote_edge, charger_edge;
  assign local_fall = deb_local_d_ff && !deb_local_ff;
  assign remote_fall = deb_remote_d_ff && !deb_remote_ff;
  assign remote_edge = deb_remote_d_ff != deb_remote_ff;
  assign charger_edge = charger_ok != charger_d_ff;
  logic on_cause;
  assign on_cause = local_fall || remote_fall || // see RULE_10
    (wakeup && !wakeup_d_ff) || (charger_ok && !charger_d_ff);

  // =====================================================
  // registers written by software
  logic off_req_pulse;
  logic sleep_req_ff, irq_clock_select_ff;
  logic [3:0] irq_mask_ff;
  logic wr_en;
  logic [7:0] wr_addr_ff;
  logic wr_pending_ff;

  // =====================================================
  // state machine
  seq_state_e state_ff, nxt_state;
  logic [10:0] seq_cnt_ff, nxt_seq_cnt;
  logic bandgap_slow_ff, nxt_bandgap_slow;
  logic no_battery, emergency;
  assign no_battery = brownout && !backup_ok; // see RULE_08
  assign emergency = brownout; // see RULE_15

  function automatic logic [10:0] step_len(input seq_state_e s,
    input logic short_counts);
    logic [10:0] n;
    n = DELAY_COUNT_TWO;
    case (s)
      ST_ON_BANDGAP: n = BANDGAP_COUNT;
      ST_ON_DELAY1: n = DELAY_COUNT_ONE;
      default: n = DELAY_COUNT_TWO;
    endcase
    // fixed counts apply unless switched on by test pin
    step_len = short_counts ? TEST_COUNT : n; // see RULE_13
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    nxt_seq_cnt = seq_cnt_ff;
    nxt_bandgap_slow = bandgap_slow_ff;
    if (no_battery)
      nxt_state = ST_NO_BATTERY;
    else
    begin
      case (state_ff)
        ST_NO_BATTERY, ST_BACKUP:
        begin
          // no switch-on from backup; main plug gives off
          if (!brownout)
            nxt_state = ST_OFF; // see RULE_06
          else
            nxt_state = ST_BACKUP; // see RULE_11
        end
        ST_OFF:
        begin
          if (emergency)
            nxt_state = ST_BACKUP;
          else if (on_cause && undervoltage_lockout_ok) // see RULE_11
          begin
            nxt_state = ST_ON_BANDGAP;
            nxt_seq_cnt = 11'h000;
            nxt_bandgap_slow = 1'b0; // see RULE_05
          end
        end
        ST_ON_BANDGAP, ST_ON_DELAY1, ST_ON_DELAY2:
        begin
          if (emergency)
          begin
            nxt_state = ST_SWITCH_OFF;
            nxt_seq_cnt = 11'h000;
          end
          else if (tick && undervoltage_lockout_ok) // see RULE_03
          begin
            if (seq_cnt_ff == step_len(state_ff, test_started_ff)
              - 11'd1)
            begin
              nxt_seq_cnt = 11'h000;
              case (state_ff)
                ST_ON_BANDGAP: nxt_state = ST_ON_DELAY1;
                ST_ON_DELAY1: nxt_state = ST_ON_DELAY2;
                default:
                begin
                  nxt_state = ST_ACTIVE;
                  nxt_bandgap_slow = 1'b1; // see RULE_05
                end
              endcase
            end
            else
              nxt_seq_cnt = seq_cnt_ff + 11'd1;
          end
        end
        ST_ACTIVE, ST_SLEEP:
        begin
          // switch-on causes have no effect here
          if (emergency || off_req_pulse) // see RULE_14
          begin
            nxt_state = ST_SWITCH_OFF;
            nxt_seq_cnt = 11'h000;
          end
          else if (sleep_req_ff)
            nxt_state = ST_SLEEP; // see RULE_17
          else
            nxt_state = ST_ACTIVE;
        end
        ST_SWITCH_OFF:
        begin
          // causes are not looked at until this ends
          if (tick) // see RULE_16
          begin
            if (seq_cnt_ff == step_len(ST_ON_DELAY1,
              test_started_ff) - 11'd1)
            begin
              nxt_state = emergency ? ST_BACKUP : ST_OFF; // see RULE_04
              nxt_seq_cnt = 11'h000;
              nxt_bandgap_slow = 1'b0;
            end
            else
              nxt_seq_cnt = seq_cnt_ff + 11'd1;
          end
        end
        default: nxt_state = ST_NO_BATTERY;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (seq_rst) // see RULE_01
    begin
      state_ff <= ST_NO_BATTERY;
      seq_cnt_ff <= 11'h000;
      bandgap_slow_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      seq_cnt_ff <= nxt_seq_cnt;
      bandgap_slow_ff <= nxt_bandgap_slow;
    end
  end

  // =====================================================
  // outputs from state
  logic switched_on;
  assign switched_on = state_ff == ST_ACTIVE || state_ff == ST_SLEEP;
  always_ff @(posedge CLOCK_IN)
  begin
    if (seq_rst)
    begin
      RTC_SUPPLY_OUT <= 1'b0;
      SUPPLY_ACTIVE_OUT <= 1'b0;
      SUPPLY_SLEEP_OUT <= 1'b0;
      INTERNAL_RESET_N_OUT <= 1'b0;
      BANDGAP_SLOW_OUT <= 1'b0;
      STATE_OUT <= 4'h0;
    end
    else
    begin
      RTC_SUPPLY_OUT <= nxt_state != ST_NO_BATTERY;
      SUPPLY_ACTIVE_OUT <= nxt_state == ST_ACTIVE; // see RULE_07
      SUPPLY_SLEEP_OUT <= nxt_state == ST_SLEEP; // see RULE_07
      INTERNAL_RESET_N_OUT <= nxt_state == ST_ACTIVE ||
        nxt_state == ST_SLEEP;
      BANDGAP_SLOW_OUT <= nxt_bandgap_slow;
      STATE_OUT <= nxt_state;
    end
  end

  // =====================================================
  // interrupt status
  logic [3:0] ev_status_ff;
  logic emergency_flag_ff;
  logic [31:0] clr_bits;
  logic ev_clock_ok;
  logic [3:0] ev_set;
  // without master clock, software selects slow clock
  assign ev_clock_ok = irq_clock_select_ff || master_ok; // see RULE_21
  assign ev_set = (switched_on && ev_clock_ok) ? // see RULE_21
    {ADC_EOC_IN, remote_edge, local_fall, charger_edge} : 4'h0;
  assign clr_bits = (wr_en && wr_addr_ff == OFS_IRQ_STATUS) ?
    HWDATA_IN : 32'h0;

  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      ev_status_ff <= 4'h0;
      emergency_flag_ff <= 1'b0;
    end
    else
    begin
      // a set in the clearing cycle wins
      ev_status_ff <= (ev_status_ff & ~clr_bits[3:0]) | ev_set; // see RULE_19
      emergency_flag_ff <= (emergency_flag_ff &&
        !clr_bits[EMERGENCY_BIT]) || (brownout && !brownout_d_ff); // see RULE_04
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      EMERGENCY_IRQ_N_OUT <= 1'b1;
      EVENT_IRQ_N_OUT <= 1'b1;
    end
    else
    begin
      EMERGENCY_IRQ_N_OUT <= // see RULE_18
        !(emergency_flag_ff && !test_started_ff);
      EVENT_IRQ_N_OUT <= !(|(ev_status_ff & irq_mask_ff)); // see RULE_20
    end
  end

  // =====================================================
  // ahb-lite slave, zero wait states
  logic addr_phase;
  assign addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign wr_en = wr_pending_ff;
  assign off_req_pulse = wr_en && wr_addr_ff == OFS_DEVICE_MODE &&
    HWDATA_IN[DEVICE_OFF_BIT];

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      OFS_DEVICE_MODE: d[SLEEP_REQ_BIT] = sleep_req_ff;
      OFS_POWER_DOWN: d[IRQ_CLOCK_SELECT_BIT] = irq_clock_select_ff;
      OFS_IRQ_MASK: d[3:0] = irq_mask_ff;
      OFS_IRQ_STATUS:
      begin
        d[3:0] = ev_status_ff;
        d[EMERGENCY_BIT] = emergency_flag_ff;
      end
      OFS_SEQ_STATUS: d[3:0] = state_ff;
      default: d = 32'h0;
    endcase
    read_mux = d;
  endfunction

  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      wr_pending_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      HRDATA_OUT <= 32'h0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
    else
    begin
      wr_pending_ff <= addr_phase && HWRITE_IN;
      if (addr_phase)
        wr_addr_ff <= HADDR_IN;
      if (addr_phase && !HWRITE_IN)
        HRDATA_OUT <= read_mux(HADDR_IN);
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (sys_rst)
    begin
      sleep_req_ff <= 1'b0;
      irq_clock_select_ff <= 1'b0;
      irq_mask_ff <= IRQ_MASK_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr_ff == OFS_DEVICE_MODE)
        sleep_req_ff <= HWDATA_IN[SLEEP_REQ_BIT];
      if (wr_addr_ff == OFS_POWER_DOWN)
        irq_clock_select_ff <= HWDATA_IN[IRQ_CLOCK_SELECT_BIT];
      if (wr_addr_ff == OFS_IRQ_MASK)
        irq_mask_ff <= HWDATA_IN[3:0];
    end
  end

  // =====================================================
  // checks
  sequence s_device_off;
    off_req_pulse && !no_battery && !emergency;
  endsequence

  a_rail_holds_fsm: assert property (@(posedge CLOCK_IN) // see RULE_01
    !rail_ok |=> state_ff == ST_NO_BATTERY)
    else $error("sequencer not held by rail reset");
  a_test_pin_reset: assert property (@(posedge CLOCK_IN) // see RULE_02
    !test_rst_n |=> EVENT_IRQ_N_OUT && ev_status_ff == 4'h0)
    else $error("test reset did not clear events");
  a_lockout_hold: assert property (@(posedge CLOCK_IN) // see RULE_03
    disable iff (seq_rst)
    state_ff inside {ST_ON_BANDGAP, ST_ON_DELAY1, ST_ON_DELAY2} &&
    !undervoltage_lockout_ok && !emergency |=> $stable(seq_cnt_ff) && $stable(state_ff))
    else $error("switch-on advanced below lockout");
  a_brownout_irq: assert property (@(posedge CLOCK_IN) // see RULE_18
    disable iff (sys_rst)
    brownout && !brownout_d_ff && !test_started_ff |=> ##1
    !EMERGENCY_IRQ_N_OUT)
    else $error("emergency interrupt missing");
  a_test_masks_irq: assert property (@(posedge CLOCK_IN) // see RULE_18
    disable iff (sys_rst)
    test_started_ff |=> EMERGENCY_IRQ_N_OUT)
    else $error("emergency not masked after test reset");
  a_active_bandgap: assert property (@(posedge CLOCK_IN) // see RULE_05
    disable iff (seq_rst)
    state_ff == ST_ON_DELAY2 ##1 state_ff == ST_ACTIVE |->
    bandgap_slow_ff && BANDGAP_SLOW_OUT)
    else $error("bandgap not slow after switch-on");
  a_no_battery: assert property (@(posedge CLOCK_IN) // see RULE_08
    disable iff (seq_rst)
    no_battery |=> state_ff == ST_NO_BATTERY && !RTC_SUPPLY_OUT)
    else $error("no-battery state not entered");
  a_off_request: assert property (@(posedge CLOCK_IN) // see RULE_14
    disable iff (seq_rst)
    switched_on ##0 s_device_off |=> state_ff == ST_SWITCH_OFF)
    else $error("device-off ignored");
  a_off_completes: assert property (@(posedge CLOCK_IN) // see RULE_16
    disable iff (seq_rst)
    state_ff == ST_SWITCH_OFF && !no_battery |=>
    state_ff inside {ST_SWITCH_OFF, ST_OFF, ST_BACKUP})
    else $error("switch-off interrupted");
  a_backup_no_on: assert property (@(posedge CLOCK_IN) // see RULE_11
    disable iff (seq_rst)
    state_ff == ST_BACKUP |=> state_ff != ST_ON_BANDGAP)
    else $error("switch-on from backup");
  a_event_gated: assert property (@(posedge CLOCK_IN) // see RULE_21
    disable iff (sys_rst)
    !switched_on |=> (ev_status_ff & ~$past(ev_status_ff)) == 4'h0)
    else $error("event latched outside active or sleep");
  a_active_supply: assert property (@(posedge CLOCK_IN) // see RULE_07
    disable iff (seq_rst)
    state_ff == ST_ACTIVE |-> SUPPLY_ACTIVE_OUT &&
    INTERNAL_RESET_N_OUT && !SUPPLY_SLEEP_OUT)
    else $error("active supplies wrong");
endmodule
`default_nettype wire

// ---- shared/power_sequencer_pkg.sv ----
// Overview of operation
// RULE_01: supply-rail power-on reset holds state machine
// RULE_02: test reset pin resets everything unconditionally
// RULE_03: switch-on steps advance only above lockout threshold
// RULE_04: brownout raises emergency interrupt, sequences to backup
// RULE_05: bandgap fast at start, slow after switch-on
// RULE_06: after power-on rest in off, rtc only
// RULE_07: active enables all, sleep selected supplies
// RULE_08: no usable battery enters no-battery state
// RULE_09: one shared debouncer, other button queued
// RULE_10: buttons, wakeup edge, charger start switch-on
// RULE_11: no switch-on below lockout or in backup
// RULE_12: sequences timed by the slow clock
// RULE_13: step counts 1031, 21 and 14 ticks
// RULE_14: device-off bit starts switch-off sequence
// RULE_15: battery below brownout starts emergency switch-off
// RULE_16: switch-off completes despite switch-on causes
// RULE_17: switched on ignores causes, events still interrupt
// RULE_18: emergency interrupt low, masked after test reset
// RULE_19: masked active-low event interrupt from events
// RULE_20: converter end-of-conversion is an event too
// RULE_21: events only active or sleep, clock needed
// RULE_22: debounce lasts 1034 slow clock periods
// RULE_23: external inputs synchronised before use
package power_sequencer_pkg;
  // =====================================================
  // register map
  localparam logic [7:0] OFS_DEVICE_MODE = 8'h00;
  localparam logic [7:0] OFS_POWER_DOWN = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SEQ_STATUS = 8'h10;
  localparam int DEVICE_OFF_BIT = 0;
  localparam int SLEEP_REQ_BIT = 1;
  localparam int IRQ_CLOCK_SELECT_BIT = 6;
  localparam int EV_CHARGER_BIT = 0;
  localparam int EV_LOCAL_BIT = 1;
  localparam int EV_REMOTE_BIT = 2;
  localparam int EV_ADC_BIT = 3;
  localparam int EMERGENCY_BIT = 7;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  // =====================================================
  // timing, in slow clock periods
  localparam logic [10:0] BANDGAP_COUNT = 11'd1031;
  localparam logic [10:0] DELAY_COUNT_ONE = 11'd21;
  localparam logic [10:0] DELAY_COUNT_TWO = 11'd14;
  localparam logic [10:0] DEBOUNCE_COUNT = 11'd1034;
  localparam logic [10:0] TEST_COUNT = 11'd1;
  // synchroniser idle: test pin high, rail low, brownout, backup ok,
  // buttons released
  localparam logic [10:0] SYNC_IDLE = 11'h4d8;
  // =====================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_NO_BATTERY = 4'b0000,
    ST_BACKUP = 4'b0001,
    ST_OFF = 4'b0010,
    ST_ON_BANDGAP = 4'b0011,
    ST_ON_DELAY1 = 4'b0100,
    ST_ON_DELAY2 = 4'b0101,
    ST_ACTIVE = 4'b0110,
    ST_SLEEP = 4'b0111,
    ST_SWITCH_OFF = 4'b1000
  } seq_state_e;
endpackage

// ---- tb/far_side_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// battery, comparators, buttons and slow oscillator
module far_side_model
(
  // system clock
  input wire logic clk_in,
  // oscillator and clock presence
  output logic slow_clock_out,
  output logic master_clock_ok_out,
  // comparator levels
  output logic rail_ok_out,
  output logic undervoltage_lockout_ok_out,
  output logic brownout_out,
  output logic backup_ok_out,
  output logic charger_ok_out,
  // buttons, pressed low, and wakeup line
  output logic local_n_out,
  output logic remote_n_out,
  output logic wakeup_out
);
  logic [1:0] div_ff = 2'h0;
  // free running like a crystal; sped up so counts finish quickly
  always @(posedge clk_in)
    div_ff <= div_ff + 2'h1;
  assign slow_clock_out = div_ff[1];
  initial
  begin
    master_clock_ok_out = 1'b1;
    {rail_ok_out, undervoltage_lockout_ok_out, brownout_out, backup_ok_out} = 4'b1001;
    charger_ok_out = 1'b0;
    {local_n_out, remote_n_out, wakeup_out} = 3'b110;
  end
  // rail, lockout, brownout, backup, charger
  task automatic set_lv(input logic [4:0] v);
    {rail_ok_out, undervoltage_lockout_ok_out, brownout_out} <= v[4:2];
    {backup_ok_out, charger_ok_out} <= v[1:0];
  endtask
  // local, remote, wakeup
  task automatic set_btn(input logic [2:0] v);
    {local_n_out, remote_n_out, wakeup_out} <= v;
  endtask
  // fast clock presence; without it software sets the select bit
  task automatic set_clk_ok(input logic v);
    master_clock_ok_out <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_power_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD t=%0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module tb_power_sequencer
  import power_sequencer_pkg::*;
;
  // ======================================================
  // signals
  localparam int TK = 4;
  localparam int ON_T = int'(BANDGAP_COUNT + DELAY_COUNT_ONE
    + DELAY_COUNT_TWO) * TK;
  localparam int DB_T = int'(DEBOUNCE_COUNT) * TK;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic test_n = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic adc = 1'b0;
  logic [31:0] hrdata, q;
  logic hready, hresp, rtc, sup_act, sup_slp, irst_n, bg_slow, emg_n, ev_n;
  logic [3:0] state;
  logic slow, mclk_ok, rail, undervoltage_lockout, bo, bk, chg, loc_n, rem_n, wake;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  always #10 clk = ~clk;
  // ======================================================
  // instances
  far_side_model P (.clk_in(clk), .slow_clock_out(slow),
    .master_clock_ok_out(mclk_ok), .rail_ok_out(rail), .undervoltage_lockout_ok_out(undervoltage_lockout),
    .brownout_out(bo), .backup_ok_out(bk), .charger_ok_out(chg),
    .local_n_out(loc_n), .remote_n_out(rem_n), .wakeup_out(wake));
  power_sequencer DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .TEST_RESET_N_IN(test_n), .SUPPLY_RAIL_OK_IN(rail),
    .UNDERVOLTAGE_LOCKOUT_OK_IN(undervoltage_lockout), .BATTERY_BROWNOUT_SENSE_IN(bo),
    .BACKUP_BATTERY_OK_IN(bk), .CHARGER_VOLTAGE_OK_IN(chg),
    .LOCAL_POWER_BUTTON_N_IN(loc_n), .REMOTE_POWER_BUTTON_N_IN(rem_n),
    .WAKEUP_REQUEST_IN(wake), .SLOW_CLOCK_IN(slow),
    .MASTER_CLOCK_OK_IN(mclk_ok), .ADC_EOC_IN(adc),
    .RTC_SUPPLY_OUT(rtc), .SUPPLY_ACTIVE_OUT(sup_act),
    .SUPPLY_SLEEP_OUT(sup_slp), .INTERNAL_RESET_N_OUT(irst_n),
    .BANDGAP_SLOW_OUT(bg_slow), .EMERGENCY_IRQ_N_OUT(emg_n),
    .EVENT_IRQ_N_OUT(ev_n), .STATE_OUT(state));
  // ======================================================
  // tasks
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hold each phase until hready is seen high at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    i = 0;
    do @(posedge clk); while (hready !== 1'b1 && ++i < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    do @(posedge clk); while (hready !== 1'b1 && ++i < 40);
    q = hrdata;
    `CHK(hresp, 1'b0)
    if (i >= 40)
    begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic wst(input logic [3:0] s, input int lim);
    n = 0;
    while (state !== s && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(state, s)
    if (state !== s)
      final_report();
  endtask
  task automatic wirq(input int lim);
    n = 0;
    while (ev_n !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(ev_n, 1'b0)
    if (ev_n !== 1'b0)
      final_report();
  endtask
  task automatic wake_edge();
    P.set_btn(3'b110);
    repeat (8) @(posedge clk);
    P.set_btn(3'b111);
  endtask
  task automatic adc_pulse();
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ======================================================
  // sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wst(ST_OFF, 50);
    `CHK(rtc, 1'b1)
    `CHK({sup_act, irst_n, bg_slow, emg_n, ev_n}, 5'b00011)
    rdc(OFS_IRQ_MASK, 32'h0);
    rdc(8'h40, 32'h0);
    P.set_btn(3'b111);
    repeat (40) @(posedge clk);
    `CHK(state, ST_OFF)
    P.set_lv(5'b11010);
    wake_edge();
    wst(ST_ON_BANDGAP, 20);
    wst(ST_ACTIVE, 6000);
    `CHK(n >= ON_T - 12 && n <= ON_T + 12, 1'b1)
    `CHK({sup_act, irst_n, bg_slow}, 3'b111)
    wr(OFS_IRQ_MASK, 32'hf);
    P.set_btn(3'b011);
    wirq(5000);
    `CHK(n >= DB_T - 4 && n <= DB_T + 24, 1'b1)
    `CHK(state, ST_ACTIVE)
    rdc(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_STATUS, 32'h2);
    P.set_btn(3'b111);
    repeat (3) @(posedge clk);
    `CHK(ev_n, 1'b1)
    adc_pulse();
    `CHK(ev_n, 1'b0)
    wr(OFS_IRQ_STATUS, 32'h8);
    wr(OFS_IRQ_MASK, 32'h0);
    adc_pulse();
    `CHK(ev_n, 1'b1)
    wr(OFS_IRQ_STATUS, 32'h8);
    wr(OFS_DEVICE_MODE, 32'h2);
    repeat (3) @(posedge clk);
    `CHK({state, sup_slp, sup_act}, {ST_SLEEP, 2'b10})
    wr(OFS_DEVICE_MODE, 32'h0);
    wst(ST_ACTIVE, 10);
    wr(OFS_DEVICE_MODE, 32'h1);
    wake_edge();
    `CHK(state, ST_SWITCH_OFF)
    wst(ST_OFF, 200);
    repeat (40) @(posedge clk);
    `CHK(state, ST_OFF)
    // lockout dropped across the bandgap step must hold the sequence
    wake_edge();
    wst(ST_ON_BANDGAP, 20);
    P.set_lv(5'b10010);
    repeat (4600) @(posedge clk);
    `CHK(state, ST_ON_BANDGAP)
    P.set_lv(5'b11010);
    wst(ST_ACTIVE, 6000);
    P.set_lv(5'b11110);
    repeat (8) @(posedge clk);
    `CHK({emg_n, state}, {1'b0, ST_SWITCH_OFF})
    wst(ST_BACKUP, 200);
    wake_edge();
    repeat (40) @(posedge clk);
    `CHK(state, ST_BACKUP)
    rdc(OFS_IRQ_STATUS, 32'h80);
    wr(OFS_IRQ_STATUS, 32'h80);
    repeat (3) @(posedge clk);
    `CHK(emg_n, 1'b1)
    P.set_lv(5'b11100);
    wst(ST_NO_BATTERY, 50);
    `CHK(rtc, 1'b0)
    P.set_lv(5'b11010);
    wst(ST_OFF, 50);
    test_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({state, emg_n, ev_n}, {ST_NO_BATTERY, 2'b11})
    test_n <= 1'b1;
    wst(ST_OFF, 50);
    P.set_lv(5'b11011);
    wst(ST_ACTIVE, 200);
    P.set_clk_ok(1'b0);
    P.set_lv(5'b11010);
    repeat (6) @(posedge clk);
    rdc(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_POWER_DOWN, 32'h40);
    P.set_lv(5'b11011);
    repeat (6) @(posedge clk);
    rdc(OFS_IRQ_STATUS, 32'h1);
    P.set_lv(5'b11110);
    repeat (12) @(posedge clk);
    `CHK(emg_n, 1'b1)
    P.set_lv(5'b01010);
    repeat (6) @(posedge clk);
    `CHK(state, ST_NO_BATTERY)
    final_report();
  end
endmodule
`default_nettype wire
